// ==== src/sdram_bank_end.sv ====
`timescale 1ns/1ps
`default_nettype none
module sdram_bank_end
   import sdram_pkg::*;
#(
   parameter int CAS_LAT = CAS_LAT_DEF,
   parameter int WR_CYC = WRITE_RECOVERY_DEF
)
(
   input wire logic mclk_i,
   input wire logic srst_i,
   sdram_link_if.device link,
   output logic [7:0] bank_state_o,
   output logic burst_busy_o,
   output logic [1:0] burst_bank_o,
   output logic bank_close_o
);
   typedef struct packed {
      bank_state_t [BANKS-1:0] bst;
      logic [BANKS-1:0][3:0] btmr;
      logic busy;
      logic rd;
      logic ap;
      logic [1:0] bank;
      logic [2:0] col;
      logic [2:0] left;
      logic dqm;
      logic close;
      logic [CAS_LAT-1:0] pv;
      logic [CAS_LAT-1:0][15:0] pd;
      logic [WORDS-1:0][15:0] mem;
   } state_t;

   state_t q;
   state_t n;
   logic [3:0] cmd;
   logic is_rd;
   logic is_wr;
   logic beat;
   logic b_rd;
   logic [1:0] b_bank;
   logic [2:0] b_col;
   logic close;

   always_comb
   begin
      cmd = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
      is_rd = cmd == CMD_RD;
      is_wr = cmd == CMD_WR;
      n = q;
      n.dqm = link.dqm;
      beat = 1'b0;
      b_rd = q.rd;
      b_bank = q.bank;
      b_col = q.col;
      close = 1'b0;
      // Bank timers
      for (int b = 0; b < BANKS; b++)
      begin
         if (q.btmr[b] > 4'h1)
         begin
            n.btmr[b] = q.btmr[b] - 4'h1;
         end
         else if (q.bst[b] == BK_RECOVER)
         begin
            n.bst[b] = BK_PRECHG;
            n.btmr[b] = PRECHARGE_CYC;
         end
         else if (q.bst[b] == BK_PRECHG)
         begin
            n.bst[b] = BK_IDLE;
            n.btmr[b] = 4'h0;
         end
      end
      // Read pipeline moves toward the pins
      for (int i = 0; i < CAS_LAT - 1; i++)
      begin
         n.pv[i] = q.pv[i + 1];
         n.pd[i] = q.pd[i + 1];
      end
      n.pv[CAS_LAT-1] = 1'b0;
      if (is_rd || is_wr)
      begin
         // Burst on another bank is cut here
         if (q.busy && q.bank != link.ba)
         begin
            close = q.ap;
         end
         if (is_wr && q.rd)
         begin
            n.pv = '0;
         end
         n.busy = BURST_LEN > 3'h1;
         n.rd = is_rd;
         n.ap = link.ap;
         n.bank = link.ba;
         n.col = link.col + 3'h1;
         n.left = BURST_LEN - 3'h1;
         beat = 1'b1;
         b_rd = is_rd;
         b_bank = link.ba;
         b_col = link.col;
      end
      else if (cmd == CMD_TERM && q.busy)
      begin
         n.busy = 1'b0;
         close = q.ap;
      end
      else if (q.busy)
      begin
         beat = 1'b1;
         n.col = q.col + 3'h1;
         n.left = q.left - 3'h1;
         if (q.left == 3'h1)
         begin
            n.busy = 1'b0;
            close = q.ap;
         end
      end
      // Deferred close of the bank that was bursting
      if (close)
      begin
         if (q.rd)
         begin
            n.bst[q.bank] = BK_PRECHG;
            n.btmr[q.bank] = PRECHARGE_CYC;
         end
         else
         begin
            n.bst[q.bank] = BK_RECOVER;
            n.btmr[q.bank] = 4'(WR_CYC);
         end
      end
      n.close = close;
      // One data beat
      if (beat && b_rd)
      begin
         n.pv[CAS_LAT-1] = 1'b1;
         n.pd[CAS_LAT-1] = q.mem[word_index(b_bank, b_col)];
      end
      else if (beat && !link.dqm)
      begin
         n.mem[word_index(b_bank, b_col)] = link.dq;
      end
      if (cmd == CMD_ACT && q.bst[link.ba] == BK_IDLE)
      begin
         n.bst[link.ba] = BK_ACTIVE;
      end
      if (cmd == CMD_PRE)
      begin
         for (int b = 0; b < BANKS; b++)
         begin
            if ((link.ap || link.ba == 2'(b)) && q.bst[b] == BK_ACTIVE)
            begin
               n.bst[b] = BK_PRECHG;
               n.btmr[b] = PRECHARGE_CYC;
            end
         end
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         q <= '0;
      end
      else
      begin
         q <= n;
      end
   end

   // Mask one clock ahead keeps the pins quiet
   assign link.dq_d = q.pd[0];
   assign link.dq_d_oe = q.pv[0] & ~q.dqm;
   assign bank_state_o = {q.bst[3], q.bst[2], q.bst[1], q.bst[0]};
   assign burst_busy_o = q.busy;
   assign burst_bank_o = q.bank;
   assign bank_close_o = q.close;
endmodule // sdram_bank_end
`default_nettype wire

// ==== src/sdram_cmd_end.sv ====
`timescale 1ns/1ps
`default_nettype none
module sdram_cmd_end
   import sdram_pkg::*;
#(
   parameter int CAS_LAT = CAS_LAT_DEF
)
(
   input wire logic mclk_i,
   input wire logic srst_i,
   sdram_link_if.host link,
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire host_op_t req_op_i,
   input wire logic [1:0] req_bank_i,
   input wire logic [2:0] req_col_i,
   input wire logic req_ap_i,
   input wire logic [15:0] wdata_i,
   output logic wdata_take_o,
   output logic [15:0] rdata_o,
   output logic rdata_valid_o
);
   typedef enum logic {H_RUN, H_LEAD} hstate_t;
   typedef struct packed {
      hstate_t st;
      logic [1:0] lead;
      logic [3:0] cmd;
      logic [1:0] ba;
      logic [2:0] col;
      logic ap;
      logic dqm;
      logic [15:0] dq;
      logic oe;
      logic [2:0] wleft;
      logic [3:0] rleft;
      logic rap;
      logic [15:0] rdata;
      logic rvalid;
   } state_t;

   localparam logic [3:0] RD_SPAN = 4'(CAS_LAT) + 4'(BURST_LEN);

   state_t q;
   state_t n;
   logic issue;
   logic need_lead;

   always_comb
   begin
      n = q;
      n.cmd = CMD_NOP;
      n.rdata = link.dq;
      n.rvalid = link.dq_d_oe;
      n.rleft = (q.rleft != 4'h0) ? q.rleft - 4'h1 : 4'h0;
      need_lead = req_op_i == OP_WR && q.rleft != 4'h0;
      issue = 1'b0;
      case (q.st)
         H_RUN:
         begin
            if (req_valid_i && need_lead)
            begin
               n.st = H_LEAD;
               n.dqm = 1'b1;
               n.lead = q.rap ? 2'h1 : 2'h0;
            end
            else
            begin
               issue = req_valid_i;
            end
         end
         H_LEAD:
         begin
            n.dqm = 1'b1;
            if (q.lead == 2'h0)
            begin
               issue = req_valid_i;
               n.st = H_RUN;
            end
            else
            begin
               n.lead = q.lead - 2'h1;
            end
         end
         default:
         begin
            n.st = H_RUN;
         end
      endcase
      // Write beats follow the command
      if (q.wleft != 3'h0)
      begin
         n.wleft = q.wleft - 3'h1;
         n.dq = wdata_i;
      end
      else
      begin
         n.oe = 1'b0;
      end
      if (issue)
      begin
         n.ba = req_bank_i;
         n.col = req_col_i;
         n.ap = req_ap_i;
         case (req_op_i)
            OP_ACT: n.cmd = CMD_ACT;
            OP_RD:
            begin
               n.cmd = CMD_RD;
               n.oe = 1'b0;
               n.wleft = 3'h0;
               n.rleft = RD_SPAN;
               n.rap = req_ap_i;
               n.dqm = 1'b0;
            end
            OP_WR:
            begin
               n.cmd = CMD_WR;
               n.oe = 1'b1;
               n.dq = wdata_i;
               n.wleft = BURST_LEN - 3'h1;
               n.rleft = 4'h0;
               n.dqm = 1'b0;
            end
            OP_PRE: n.cmd = CMD_PRE;
            OP_TERM:
            begin
               n.cmd = CMD_TERM;
               n.oe = 1'b0;
               n.wleft = 3'h0;
            end
            default: n.cmd = CMD_NOP;
         endcase
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         q <= '0;
         q.cmd <= CMD_INHIBIT;
      end
      else
      begin
         q <= n;
      end
   end

   assign req_ready_o = issue;
   assign wdata_take_o = (issue && req_op_i == OP_WR) || q.wleft != 3'h0;
   assign {link.cs_n, link.ras_n, link.cas_n, link.we_n} = q.cmd;
   assign link.ba = q.ba;
   assign link.col = q.col;
   assign link.ap = q.ap;
   assign link.dqm = q.dqm;
   assign link.dq_h = q.dq;
   assign link.dq_h_oe = q.oe;
   assign rdata_o = q.rdata;
   assign rdata_valid_o = q.rvalid;
endmodule // sdram_cmd_end
`default_nettype wire

// ==== src/sdram_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface sdram_link_if (input wire logic mclk_i);
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic [1:0] ba;
   logic [2:0] col;
   logic ap;
   logic dqm;
   logic [15:0] dq_h;
   logic dq_h_oe;
   logic [15:0] dq_d;
   logic dq_d_oe;
   logic [15:0] dq;
   // Bus level from the two enables; undriven reads as zero
   assign dq = dq_h_oe ? dq_h : (dq_d_oe ? dq_d : 16'h0000);
   modport device (input cs_n, ras_n, cas_n, we_n, ba, col, ap, dqm, dq,
                   output dq_d, dq_d_oe);
   modport host (output cs_n, ras_n, cas_n, we_n, ba, col, ap, dqm,
                 dq_h, dq_h_oe, input dq, dq_d_oe);
endinterface
`default_nettype wire

// ==== src/sdram_pkg.sv ====
// Notes on behaviour
// - Auto-precharge burst cut by another bank or by terminate closes its own bank
// - Non-interrupting commands leave ongoing burst untouched
// - Read interrupts read; old data until latency
// - Write ends read at once; mask one clock
// - Read ends write; last word precedes read
// - Write ends write; last word precedes it
// - Read-ap cut by read: precharge at cut
// - Read-ap cut by write: mask two clocks
// - Write-ap cut by read: recovery, then precharge
// - Write-ap cut by write: recovery, then precharge
// - Precharge period elapsed returns bank to idle
package sdram_pkg;
   localparam int BANKS = 4;
   localparam int DATA_W = 16;
   localparam int WORDS = 32;
   localparam logic [2:0] BURST_LEN = 3'h4;
   localparam int CLK_PERIOD_NS = 50;
   localparam int PRECHARGE_PERIOD_NS = 19;
   localparam int PRE_RAW =
      (PRECHARGE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] PRECHARGE_CYC = 4'(PRE_RAW < 1 ? 1 : PRE_RAW);
   localparam int CAS_LAT_DEF = 2;
   localparam int WRITE_RECOVERY_DEF = 2;
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [3:0] CMD_ACT = 4'h3;
   localparam logic [3:0] CMD_RD = 4'h5;
   localparam logic [3:0] CMD_WR = 4'h4;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_TERM = 4'h6;
   localparam logic [3:0] CMD_INHIBIT = 4'hf;
   typedef enum logic [1:0] {BK_IDLE, BK_ACTIVE, BK_PRECHG, BK_RECOVER}
      bank_state_t;
   typedef enum logic [2:0] {OP_ACT, OP_RD, OP_WR, OP_PRE, OP_TERM}
      host_op_t;
   function automatic logic [4:0] word_index(input logic [1:0] bank,
                                             input logic [2:0] col);
      return {bank, col};
   endfunction
endpackage

// ==== verif/bank_burst_interrupt_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module bank_burst_interrupt_asserts #(
   parameter int CAS_LAT = 2
)
(
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic ap,
   input wire logic dqm,
   input wire logic dq_h_oe,
   input wire logic dq_d_oe
);
   logic rd, wr, nop, ap_q;
   logic [3:0] left_q;
   assign rd = {cs_n, ras_n, cas_n, we_n} == 4'h5;
   assign wr = {cs_n, ras_n, cas_n, we_n} == 4'h4;
   assign nop = {cs_n, ras_n, cas_n, we_n} == 4'h7 && !dqm;
   // Read words still due
   always_ff @(posedge mclk_i)
   begin
      if (srst_i || wr)
         left_q <= 4'h0;
      else if (rd)
         left_q <= 4'(CAS_LAT + 3);
      else if (left_q != 4'h0)
         left_q <= left_q - 4'h1;
      if (rd)
         ap_q <= ap;
   end
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (srst_i);
   property p_rd_lat;
      rd ##1 nop |-> ##(CAS_LAT - 1) dq_d_oe;
   endproperty
   a_rd_lat: assert property (p_rd_lat)
      else $error("read data late");
   property p_wr_drop;
      wr |-> !dq_d_oe ##1 !dq_d_oe;
   endproperty
   a_wr_drop: assert property (p_wr_drop)
      else $error("read data after write");
   property p_no_clash;
      !(dq_h_oe && dq_d_oe);
   endproperty
   a_no_clash: assert property (p_no_clash)
      else $error("both ends drive data");
   property p_mask1;
      wr && left_q != 4'h0 |-> $past(dqm);
   endproperty
   a_mask1: assert property (p_mask1)
      else $error("no mask before write");
   property p_mask2;
      wr && left_q != 4'h0 && ap_q |-> $past(dqm, 2);
   endproperty
   a_mask2: assert property (p_mask2)
      else $error("no early mask");
   // Figures for latency two
   property p_rd_len;
      rd ##1 nop [*6] |-> !dq_d_oe && $past(dq_d_oe) && $past(dq_d_oe, 4);
   endproperty
   a_rd_len: assert property (p_rd_len)
      else $error("read burst length wrong");
   property p_rd_rd;
      rd ##1 (rd && !dqm) ##1 nop [*2] |-> dq_d_oe && $past(dq_d_oe);
   endproperty
   a_rd_rd: assert property (p_rd_rd)
      else $error("cut read words lost");
   property p_rd_wr;
      rd ##1 !wr |-> !dq_h_oe;
   endproperty
   a_rd_wr: assert property (p_rd_wr)
      else $error("write data after read");
endmodule // bank_burst_interrupt_asserts
`default_nettype wire

// ==== verif/bank_burst_interrupt_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module bank_burst_interrupt_tb
   import sdram_pkg::*;
;
   localparam int CL = 2;
   typedef struct packed {
      logic [1:0] bank;
      logic [2:0] col;
      logic [15:0] base;
   } row_t;
   row_t rows [4] = '{'{2'h0, 3'h0, 16'h1000}, '{2'h1, 3'h6, 16'h2000},
      '{2'h2, 3'h3, 16'h3000}, '{2'h3, 3'h1, 16'h4000}};
   logic mclk_i = 1'b0;
   logic srst_i = 1'b1;
   logic req_valid_i = 1'b0;
   host_op_t req_op_i = OP_ACT;
   logic [1:0] req_bank_i = 2'h0;
   logic [2:0] req_col_i = 3'h0;
   logic req_ap_i = 1'b0;
   logic [15:0] wdata_i = 16'h0000;
   logic req_ready_o, wdata_take_o, rdata_valid_o, burst_busy_o, bank_close_o;
   logic [15:0] rdata_o;
   logic [7:0] bank_state_o;
   logic [1:0] burst_bank_o;
   logic [15:0] mem [4][8] = '{default: 16'h0000};
   logic [15:0] got [$];
   int fail_count = 0;
   int n_checks = 0;
   int cyc = 0;
   int closes = 0;
   initial
   begin
      forever #25 mclk_i = ~mclk_i;
   end
   sdram_link_if link (.mclk_i(mclk_i));
   sdram_bank_end #(.CAS_LAT(CL)) u_sdram_bank_end (.mclk_i(mclk_i),
      .srst_i(srst_i), .link(link), .bank_state_o(bank_state_o),
      .burst_busy_o(burst_busy_o), .burst_bank_o(burst_bank_o),
      .bank_close_o(bank_close_o));
   sdram_cmd_end #(.CAS_LAT(CL)) u_sdram_cmd_end (.mclk_i(mclk_i),
      .srst_i(srst_i), .link(link), .req_valid_i(req_valid_i),
      .req_ready_o(req_ready_o), .req_op_i(req_op_i),
      .req_bank_i(req_bank_i), .req_col_i(req_col_i), .req_ap_i(req_ap_i),
      .wdata_i(wdata_i), .wdata_take_o(wdata_take_o), .rdata_o(rdata_o),
      .rdata_valid_o(rdata_valid_o));
   bank_burst_interrupt_asserts #(.CAS_LAT(CL))
      u_bank_burst_interrupt_asserts (.mclk_i(mclk_i), .srst_i(srst_i),
      .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n),
      .we_n(link.we_n), .ap(link.ap), .dqm(link.dqm),
      .dq_h_oe(link.dq_h_oe), .dq_d_oe(link.dq_d_oe));
   task automatic tally_and_finish();
      if (fail_count == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] e,
                      input logic [15:0] a);
      n_checks++;
      if (a !== e)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, e, a);
      end
   endtask
   // Read words, write data feed, close pulses, hang limit
   always @(posedge mclk_i)
   begin
      cyc <= cyc + 1;
      if (rdata_valid_o === 1'b1)
         got.push_back(rdata_o);
      if (bank_close_o === 1'b1)
         closes <= closes + 1;
      if (wdata_take_o === 1'b1)
         wdata_i <= wdata_i + 16'h0001;
      if (cyc == 1000)
      begin
         fail_count++;
         tally_and_finish();
      end
   end
   task automatic req(input host_op_t op, input logic [1:0] b,
                      input logic [2:0] c, input logic a);
      int n;
      n = 0;
      req_valid_i <= 1'b1;
      req_op_i <= op;
      req_bank_i <= b;
      req_col_i <= c;
      req_ap_i <= a;
      do
      begin
         @(negedge mclk_i);
         n++;
      end while (req_ready_o !== 1'b1 && n < 20);
      chk("request taken", 16'h0001, 16'(n < 20));
      @(posedge mclk_i);
   endtask
   task automatic idle(input int n);
      req_valid_i <= 1'b0;
      repeat (n) @(posedge mclk_i);
   endtask
   task automatic drain(input logic [1:0] b, input logic [2:0] c,
                        input int n);
      chk("word count", 16'(n), 16'(got.size()));
      for (int i = 0; i < n; i++)
         chk("read word", mem[b][3'(c + i)], got[i]);
      got.delete();
   endtask
   task automatic wait_st(input logic [1:0] b, input logic [1:0] v);
      int n;
      n = 0;
      do
      begin
         @(negedge mclk_i);
         n++;
      end while (bank_state_o[2*b +: 2] !== v && n < 20);
      chk("bank state", {14'h0, v}, {14'h0, bank_state_o[2*b +: 2]});
      @(posedge mclk_i);
   endtask
   initial
   begin
      repeat (4) @(posedge mclk_i);
      srst_i <= 1'b0;
      @(negedge mclk_i);
      chk("reset", 16'h0, {7'h0, burst_busy_o, bank_state_o});
      @(posedge mclk_i);
      for (int b = 0; b < 4; b++)
         req(OP_ACT, 2'(b), 3'h0, 1'b0);
      foreach (rows[i])
      begin
         wdata_i <= rows[i].base;
         req(OP_WR, rows[i].bank, rows[i].col, 1'b0);
         idle(6);
         for (int k = 0; k < 4; k++)
            mem[rows[i].bank][3'(rows[i].col + k)] = rows[i].base + 16'(k);
         req(OP_RD, rows[i].bank, rows[i].col, 1'b0);
         idle(10);
         drain(rows[i].bank, rows[i].col, 4);
         chk("burst bank", {14'h0, rows[i].bank}, {14'h0, burst_bank_o});
      end
      // Write with close cut by write to another bank
      wdata_i <= 16'h5a5a;
      req(OP_WR, 2'h0, 3'h0, 1'b1);
      req(OP_WR, 2'h3, 3'h5, 1'b0);
      idle(1);
      wait_st(2'h0, 2'h3);
      wait_st(2'h0, 2'h2);
      wait_st(2'h0, 2'h0);
      chk("closes", 16'h1, 16'(closes));
      mem[0][0] = 16'h5a5a;
      req(OP_ACT, 2'h0, 3'h0, 1'b0);
      req(OP_RD, 2'h0, 3'h0, 1'b0);
      idle(10);
      drain(2'h0, 3'h0, 4);
      // Read with close cut by read
      req(OP_RD, 2'h2, 3'h3, 1'b1);
      req(OP_RD, 2'h3, 3'h1, 1'b0);
      idle(10);
      chk("cut word", mem[2][3], got.pop_front());
      drain(2'h3, 3'h1, 4);
      chk("closes", 16'h2, 16'(closes));
      // Read cut by write: no old words
      req(OP_RD, 2'h1, 3'h6, 1'b0);
      req(OP_WR, 2'h0, 3'h4, 1'b0);
      idle(10);
      drain(2'h1, 3'h6, 0);
      // Write with close cut by read
      wdata_i <= 16'hbe00;
      req(OP_WR, 2'h1, 3'h6, 1'b1);
      req(OP_RD, 2'h3, 3'h1, 1'b0);
      idle(10);
      drain(2'h3, 3'h1, 4);
      chk("closes", 16'h3, 16'(closes));
      mem[1][6] = 16'hbe00;
      req(OP_ACT, 2'h1, 3'h0, 1'b0);
      req(OP_RD, 2'h1, 3'h6, 1'b0);
      idle(10);
      drain(2'h1, 3'h6, 4);
      // Read with close cut by write: no words, bank closes
      req(OP_RD, 2'h3, 3'h1, 1'b1);
      req(OP_WR, 2'h0, 3'h4, 1'b0);
      idle(10);
      drain(2'h3, 3'h1, 0);
      chk("closes", 16'h4, 16'(closes));
      chk("bank state", 16'h0, {14'h0, bank_state_o[7:6]});
      tally_and_finish();
   end
endmodule // bank_burst_interrupt_tb
`default_nettype wire
